// >>> rtl/fdc_pkg.sv
package fdc_pkg;
  // register byte offsets
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_CMD    = 5'h04;
  localparam logic [4:0] ADDR_SLOT   = 5'h08;
  localparam logic [4:0] ADDR_CHG    = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_WORK   = 5'h14;
  localparam logic [4:0] ADDR_DFLT   = 5'h18;
  // field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_ME_LSB  = 8;
  localparam int CMD_CLEAR    = 0;
  localparam int CMD_SET      = 1;
  localparam int CMD_FACTORY  = 2;
  localparam int STAT_LOAD    = 0;
  localparam int STAT_PEND    = 8;
  // commit_field_select encodings
  localparam logic [1:0] FDOM_NONE = 2'h0;
  localparam logic [1:0] FDOM_F1   = 2'h1;
  localparam logic [1:0] FDOM_F2   = 2'h2;
  // reset values
  localparam logic [1:0]  SEL_RST  = FDOM_NONE;
  localparam logic [31:0] FACT_GLB = 32'h0000_0001;
  localparam logic [31:0] FACT_ME  = 32'h0000_0010;
  // cycles spent at boot before the default copy
  localparam logic [1:0]  BOOT_CYC = 2'h3;
  typedef enum logic {ST_BOOT, ST_RUN} fdc_state_t;
endpackage : fdc_pkg

// >>> rtl/fdc_commit.sv
// Summary of operation
// - changes commit only in pre-field vertical interval
// - no dominance: commit at very next field
// - field 1 dominance: commit only before field 1
// - field 2 dominance: commit only before field 2
// - external triggers queue like panel changes
// - power-up copies user default into working state
// - clear control reloads user default into working
// - store default captures selected bank for all
// - factory restore uses fixed read-only values
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
module fdc_commit
  import fdc_pkg::*;
#(
  parameter int N_ME = 2,
  parameter int SW   = $clog2(N_ME + 1)
) (
  input  wire logic                 i_clk,           // 10 MHz clock
  input  wire logic                 i_rst,           // sync reset, high
  input  wire logic                 i_ce,            // clock enable
  input  wire logic [4:0]           i_avs_address,   // byte address
  input  wire logic                 i_avs_read,      // read request
  input  wire logic                 i_avs_write,     // write request
  input  wire logic [31:0]          i_avs_writedata, // write data
  output logic [31:0]               o_avs_readdata,  // read data
  output logic                      o_avs_waitrequest, // stall
  input  wire logic                 i_vert_interval, // vblank, pin
  input  wire logic                 i_field_two,     // next is field 2
  input  wire logic                 i_store_valid,   // battery store ok
  input  wire logic                 i_ext_trig,      // editor/trigger
  input  wire logic [SW-1:0]        i_ext_slot,      // trigger slot
  input  wire logic [31:0]          i_ext_data,      // trigger value
  output logic                      o_commit,        // commit strobe
  output logic                      o_pending,       // change waiting
  output logic [(N_ME+1)*32-1:0]    o_working        // working state
);
  localparam int NS = N_ME + 1;

  // true when the upcoming field may take a commit
  function automatic logic field_ok(input logic [1:0] sel,
                                    input logic fld2);
    case (sel)
      FDOM_F1: field_ok = !fld2;
      FDOM_F2: field_ok = fld2;
      default: field_ok = 1'b1;
    endcase
  endfunction : field_ok

  fdc_state_t        state_q;
  logic [1:0]        boot_q;
  logic [1:0]        sel_q;
  logic [SW-1:0]     me_q;
  logic [SW-1:0]     slot_q;
  logic [31:0]       ws_q [NS];
  logic [31:0]       dflt_glb_q;
  logic [31:0]       dflt_me_q;
  logic [31:0]       pend_d_q [NS];
  logic [NS-1:0]     pend_v_q;
  logic              load_q;
  logic              ack_q;
  logic [SW+35:0]    s1_q, s2_q;
  logic              vbl3_q, trg3_q;
  logic              vbl_s, fld2_s, valid_s, trg_s;
  logic [SW-1:0]     eslot_s;
  logic [31:0]       edata_s;
  logic              vbl_rise, trg_rise, commit;
  logic              wr, rd, clr, setd, fact;
  logic [NS-1:0]     new_v;

  // two-stage synchroniser for every pin input
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (i_ce) begin
      s1_q <= {i_vert_interval, i_field_two, i_store_valid,
               i_ext_trig, i_ext_slot, i_ext_data};
      s2_q <= s1_q;
    end
  end
  assign {vbl_s, fld2_s, valid_s, trg_s, eslot_s, edata_s} = s2_q;

  // edge memory on the synchronised levels
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      vbl3_q <= 1'b0;
      trg3_q <= 1'b0;
    end else if (i_ce) begin
      vbl3_q <= vbl_s;
      trg3_q <= trg_s;
    end
  end
  assign vbl_rise = vbl_s & ~vbl3_q;
  assign trg_rise = trg_s & ~trg3_q & (state_q == ST_RUN);

  // single commit strobe at vblank start of an allowed field
  assign commit = i_ce & (state_q == ST_RUN) & vbl_rise
                & field_ok(sel_q, fld2_s);
  assign o_commit = commit;

  // bus handshake: one wait cycle, then acknowledge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr   = i_ce & i_avs_write & ack_q;
  assign rd   = i_avs_read & ~ack_q;
  assign clr  = wr & (i_avs_address == ADDR_CMD)
              & i_avs_writedata[CMD_CLEAR];
  assign setd = wr & (i_avs_address == ADDR_CMD)
              & i_avs_writedata[CMD_SET];
  assign fact = wr & (i_avs_address == ADDR_CMD)
              & i_avs_writedata[CMD_FACTORY];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  // read mux, data stands at the acknowledge edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= '0;
    end else if (i_ce && rd) begin
      case (i_avs_address)
        ADDR_CTRL: o_avs_readdata <= 32'(sel_q)
                   | (32'(me_q) << CTRL_ME_LSB);
        ADDR_SLOT:   o_avs_readdata <= 32'(slot_q);
        ADDR_STATUS: o_avs_readdata <= (32'(load_q) << STAT_LOAD)
                   | (32'(pend_v_q) << STAT_PEND);
        ADDR_WORK:   o_avs_readdata <= ws_q[slot_q];
        ADDR_DFLT:   o_avs_readdata <= (slot_q == '0) ? dflt_glb_q
                                                      : dflt_me_q;
        default:     o_avs_readdata <= '0;
      endcase
    end
  end

  // control registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_q  <= SEL_RST;
      me_q   <= SW'(1);
      slot_q <= '0;
    end else if (wr) begin
      if (i_avs_address == ADDR_CTRL) begin
        sel_q <= i_avs_writedata[CTRL_SEL_LSB +: 2];
        if (i_avs_writedata[CTRL_ME_LSB +: SW] != '0 &&
            i_avs_writedata[CTRL_ME_LSB +: SW] < SW'(NS))
          me_q <= i_avs_writedata[CTRL_ME_LSB +: SW];
      end
      if (i_avs_address == ADDR_SLOT &&
          i_avs_writedata[SW-1:0] < SW'(NS))
        slot_q <= i_avs_writedata[SW-1:0];
    end
  end

  // boot sequencer, copies default once the store level settles
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_BOOT;
      boot_q  <= '0;
    end else if (i_ce) begin
      case (state_q)
        ST_BOOT: begin
          boot_q <= boot_q + 2'h1;
          if (boot_q == BOOT_CYC)
            state_q <= ST_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // new change requests, panel or external
  always_comb begin
    new_v = '0;
    if (wr && i_avs_address == ADDR_CHG)
      new_v[slot_q] = 1'b1;
    if (trg_rise && eslot_s < SW'(NS))
      new_v[eslot_s] = 1'b1;
  end

  // pending store; a new request beats the commit clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_v_q <= '0;
      load_q   <= 1'b0;
    end else if (i_ce) begin
      pend_v_q <= (pend_v_q & ~{NS{commit}}) | new_v;
      load_q   <= (load_q & ~commit) | clr | fact;
    end
  end
  assign o_pending = |pend_v_q | load_q;

  // pending data, trigger wins if both hit one slot
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      for (int k = 0; k < NS; k++) begin
        if (wr && i_avs_address == ADDR_CHG && slot_q == SW'(k))
          pend_d_q[k] <= i_avs_writedata;
        if (trg_rise && eslot_s == SW'(k))
          pend_d_q[k] <= edata_s;
      end
    end
  end

  // default store, not reset so contents survive
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if ((state_q == ST_BOOT && boot_q == BOOT_CYC && !valid_s)
          || fact) begin
        dflt_glb_q <= FACT_GLB;
        dflt_me_q  <= FACT_ME;
      end else if (setd) begin
        dflt_glb_q <= ws_q[0];
        dflt_me_q  <= ws_q[me_q];
      end
    end
  end

  // working state: boot load, then commits only
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (state_q == ST_BOOT && boot_q == BOOT_CYC) begin
        for (int k = 0; k < NS; k++)
          ws_q[k] <= !valid_s ? (k == 0 ? FACT_GLB : FACT_ME)
                   : (k == 0 ? dflt_glb_q : dflt_me_q);
      end else if (commit) begin
        for (int k = 0; k < NS; k++) begin
          if (pend_v_q[k])
            ws_q[k] <= pend_d_q[k];
          else if (load_q)
            ws_q[k] <= (k == 0) ? dflt_glb_q : dflt_me_q;
        end
      end
    end
  end

  // flat output of the working state
  always_comb begin
    for (int k = 0; k < NS; k++)
      o_working[k*32 +: 32] = ws_q[k];
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_commit_at_vbl: assert property (commit |-> vbl_s && !vbl3_q)
    else $error("commit outside vertical interval start");
  a_none_every_field: assert property (
    i_ce && state_q == ST_RUN && vbl_rise && sel_q == FDOM_NONE
    |-> commit) else $error("no commit with dominance off");
  a_field_one_only: assert property (
    commit && sel_q == FDOM_F1 |-> !fld2_s)
    else $error("field 1 dominance committed on field 2");
  a_field_two_only: assert property (
    commit && sel_q == FDOM_F2 |-> fld2_s)
    else $error("field 2 dominance committed on field 1");
  a_ext_queued: assert property (
    i_ce && trg_rise && eslot_s == '0 |=> pend_v_q[0]
    && pend_d_q[0] == $past(edata_s))
    else $error("external trigger not queued");
  a_boot_load: assert property (
    i_ce && state_q == ST_BOOT && boot_q == BOOT_CYC && valid_s
    |=> ws_q[0] == $past(dflt_glb_q) && state_q == ST_RUN)
    else $error("power-up default not loaded");
  a_clear_load: assert property (
    commit && load_q && !pend_v_q[0] && !clr && !fact
    |=> ws_q[0] == $past(dflt_glb_q)
    && !load_q) else $error("clear did not load default");
  a_set_capture: assert property (
    setd && !fact |=> dflt_me_q == $past(ws_q[me_q]))
    else $error("default capture wrong bank");
  a_factory_rom: assert property (
    fact |=> dflt_glb_q == FACT_GLB && dflt_me_q == FACT_ME)
    else $error("factory values not restored");
  a_commit_apply: assert property (
    commit && pend_v_q[0] ##1 !commit [*2] |-> ws_q[0] ==
    $past(pend_d_q[0], 2)) else $error("pending change not applied");

  c_commit_f1: cover property (commit && sel_q == FDOM_F1);
  c_commit_f2: cover property (commit && sel_q == FDOM_F2);
  c_clear_load: cover property (commit && load_q);
  c_ext_trig: cover property (trg_rise ##[1:200] commit);
endmodule : fdc_commit

// >>> testbench/fdc_field_ref.sv
module fdc_field_ref #(
  parameter int FIELD_CYC = 40, // cycles per field
  parameter int VBI_CYC   = 8   // interval length
) (
  input  wire logic i_clk,      // bench clock
  output logic      o_vblank,   // vertical interval
  output logic      o_field_two // next field is field 2
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt_q = 0;
  logic fld_q = 1'b0;
  // free-running field timing, fields 1 and 2 alternate
  always_ff @(posedge i_clk) begin
    cnt_q <= (cnt_q == FIELD_CYC - 1) ? 0 : cnt_q + 1;
    if (cnt_q == FIELD_CYC - 1) begin
      fld_q <= ~fld_q;
    end
  end
  // interval opens each field; field flag stands for the whole field
  assign o_vblank    = cnt_q < VBI_CYC;
  assign o_field_two = fld_q;
endmodule : fdc_field_ref

// >>> testbench/testbench.sv
module testbench
  import fdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FLD = 40; // cycles per field
  logic        clk = 1'b0, rst = 1'b1, rd_en = 1'b0, wr_en = 1'b0;
  logic        trig = 1'b0, st_ok = 1'b0, wreq, vbl, fld2, cmt, pend;
  logic        ce = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [1:0]  xslot = 2'h0;
  logic [31:0] wdat = 32'h0000_0000, xdat = 32'h0000_0000, rdat, q, v;
  logic [95:0] work;
  logic [31:0] mdl [3];
  int          err_total = 0, checked = 0;
  // clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  fdc_commit #(.N_ME(2)) u_fdc_commit (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_vert_interval(vbl), .i_field_two(fld2), .i_store_valid(st_ok),
    .i_ext_trig(trig), .i_ext_slot(xslot), .i_ext_data(xdat),
    .o_commit(cmt), .o_pending(pend), .o_working(work));
  fdc_field_ref u_fdc_field_ref (
    .i_clk(clk), .o_vblank(vbl), .o_field_two(fld2));
  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic done;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= ~w;
    done = 1'b0;
    while (!done) begin
      // values settled before the edge are those that stand at it
      @(negedge clk);
      done = (wreq === 1'b0);
      r = rdat;
      @(posedge clk);
    end
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus
  task automatic check_work();
    for (int s = 0; s < 3; s++)
      chk("working", mdl[s], work[s*32+:32]);
  endtask : check_work
  // wait to just after an interval ends
  task automatic align();
    while (vbl !== 1'b1) @(negedge clk);
    while (vbl !== 1'b0) @(negedge clk);
    @(posedge clk);
  endtask : align
  task automatic wait_commit(input int lim, input logic [1:0] sel);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      if (cmt === 1'b1) break;
    end
    chk("commit seen", 32'h0000_0001, 32'(n < lim));
    chk("commit in interval", 32'h0000_0001, 32'(vbl));
    if (sel != FDOM_NONE)
      chk("commit field", 32'(sel == FDOM_F2), 32'(fld2));
    @(negedge clk);
  endtask : wait_commit
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
  endtask : do_reset
  // watchdog
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    mdl = '{FACT_GLB, FACT_ME, FACT_ME};
    do_reset();
    check_work();
    // panel and trigger changes under every dominance setting
    for (int k = 0; k < 6; k++) begin
      v = 32'hC0DE_0000 + 32'(k);
      bus(1'b1, ADDR_CTRL, 32'h0000_0100 | 32'(k / 2), q);
      align();
      if (k % 2) begin
        xslot <= 2'(k % 3);
        xdat <= v;
        @(posedge clk);
        trig <= 1'b1;
      end else begin
        bus(1'b1, ADDR_SLOT, 32'(k % 3), q);
        bus(1'b1, ADDR_CHG, v, q);
      end
      repeat (6) @(negedge clk);
      chk("pending", 32'h0000_0001, 32'(pend));
      bus(1'b0, ADDR_STATUS, 32'h0000_0000, q);
      chk("status", 32'h0000_0001 << (STAT_PEND + k % 3), q);
      wait_commit(k < 2 ? FLD + 8 : 2 * FLD + 8, 2'(k / 2));
      mdl[k % 3] = v;
      check_work();
      @(posedge clk);
      trig <= 1'b0;
    end
    // factory restore, then store bank 2 as default and clear
    bus(1'b1, ADDR_CTRL, 32'h0000_0200, q);
    bus(1'b1, ADDR_CMD, 32'h0000_0004, q);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    chk("load status", 32'h0000_0001 << STAT_LOAD, q);
    bus(1'b0, ADDR_CTRL, 32'h0000_0000, q);
    chk("control", 32'h0000_0200, q);
    wait_commit(2 * FLD + 8, FDOM_NONE);
    mdl = '{FACT_GLB, FACT_ME, FACT_ME};
    check_work();
    bus(1'b1, ADDR_SLOT, 32'h0000_0002, q);
    bus(1'b1, ADDR_CHG, 32'h5EED_0002, q);
    wait_commit(2 * FLD + 8, FDOM_NONE);
    bus(1'b1, ADDR_CMD, 32'h0000_0002, q);
    bus(1'b1, ADDR_SLOT, 32'h0000_0001, q);
    bus(1'b0, ADDR_DFLT, 32'h0000_0000, q);
    chk("default bank", 32'h5EED_0002, q);
    bus(1'b1, ADDR_CHG, 32'h0BAD_0001, q);
    wait_commit(2 * FLD + 8, FDOM_NONE);
    bus(1'b1, ADDR_CMD, 32'h0000_0001, q);
    wait_commit(2 * FLD + 8, FDOM_NONE);
    mdl = '{FACT_GLB, 32'h5EED_0002, 32'h5EED_0002};
    check_work();
    // disturb working state, then power up from the valid store
    bus(1'b1, ADDR_CHG, 32'h0BAD_0001, q);
    wait_commit(2 * FLD + 8, FDOM_NONE);
    @(posedge clk);
    st_ok <= 1'b1;
    do_reset();
    check_work();
    bus(1'b0, ADDR_WORK, 32'h0000_0000, q);
    chk("work read", FACT_GLB, q);
    // frozen clock enable holds a queued change past an interval
    align();
    bus(1'b1, ADDR_CHG, 32'hFEED_0000, q);
    ce <= 1'b0;
    repeat (2 * FLD) @(negedge clk);
    chk("frozen pending", 32'h0000_0001, 32'(pend));
    check_work();
    align();
    ce <= 1'b1;
    wait_commit(FLD + 8, FDOM_NONE);
    mdl[0] = 32'hFEED_0000;
    check_work();
    bus(1'b0, 5'h1C, 32'h0000_0000, q);
    chk("unmapped read", 32'h0000_0000, q);
    print_verdict();
  end
endmodule : testbench
